// ---- include/cpudp_map.vh ----
// constants for the processor slice: timing, microword fields, status bits
`ifndef CPUDP_MAP_VH
`define CPUDP_MAP_VH
`define CPUDP_CLK_NS      50
`define CPUDP_UCYC_NS     260
`define CPUDP_UCYC        ((`CPUDP_UCYC_NS + `CPUDP_CLK_NS - 1) / `CPUDP_CLK_NS)
// microword fields
`define CPUDP_UW_END      31
`define CPUDP_UW_OP_HI    30
`define CPUDP_UW_OP_LO    28
`define CPUDP_UW_AS_HI    27
`define CPUDP_UW_AS_LO    25
`define CPUDP_UW_BS_HI    24
`define CPUDP_UW_BS_LO    22
`define CPUDP_UW_BSRC_HI  21
`define CPUDP_UW_BSRC_LO  20
`define CPUDP_UW_WIDE     19
`define CPUDP_UW_WB_HI    18
`define CPUDP_UW_WB_LO    16
`define CPUDP_UW_OPF      15
`define CPUDP_UW_SO_HI    14
`define CPUDP_UW_SO_LO    13
`define CPUDP_UW_BI_HI    12
`define CPUDP_UW_BI_LO    10
`define CPUDP_UW_BF_HI    9
`define CPUDP_UW_BF_LO    7
`define CPUDP_UW_PM       6
`define CPUDP_UW_PMW      5
`define CPUDP_UW_FLG      4
// alu operations
`define CPUDP_OP_ADD      3'h0
`define CPUDP_OP_SUB      3'h1
`define CPUDP_OP_AND      3'h2
`define CPUDP_OP_OR       3'h3
`define CPUDP_OP_XOR      3'h4
`define CPUDP_OP_PASSB    3'h5
`define CPUDP_OP_SHL      3'h6
`define CPUDP_OP_SHR      3'h7
// register numbers within a level
`define CPUDP_R_STS       3'h0
`define CPUDP_R_D         3'h1
`define CPUDP_R_P         3'h2
`define CPUDP_R_A         3'h5
`define CPUDP_R_T         3'h6
`define CPUDP_R_X         3'h7
// status word bits
`define CPUDP_S_ION       15
`define CPUDP_S_PON       14
`define CPUDP_S_M         7
`define CPUDP_S_C         6
`define CPUDP_S_O         5
`define CPUDP_S_Q         4
`define CPUDP_S_Z         3
`define CPUDP_S_K         2
`define CPUDP_S_TG        1
`define CPUDP_S_PM        0
`endif

// ---- hdl/cpudp_alu16.v ----
// one 16-bit arithmetic slice; two of them chain into a 32-bit unit
`include "cpudp_map.vh"
module cpudp_alu16 (
  input  wire [2:0]  op,
  input  wire [15:0] a,
  input  wire [15:0] b,
  input  wire        cin,
  output reg  [15:0] y,
  output reg         cout,
  output reg         ovf
);
  reg [16:0] sum;

  // shifts put the discarded bit on cout and take cin as the fill bit
  always @* begin
    sum  = 17'h00000;
    y    = 16'h0000;
    cout = 1'b0;
    ovf  = 1'b0;
    case (op)
      `CPUDP_OP_ADD: begin
        sum  = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
        y    = sum[15:0];
        cout = sum[16];
        ovf  = (a[15] == b[15]) && (y[15] != a[15]);
      end
      `CPUDP_OP_SUB: begin
        sum  = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
        y    = sum[15:0];
        cout = sum[16];
        ovf  = (a[15] != b[15]) && (y[15] != a[15]);
      end
      `CPUDP_OP_AND:   y = a & b;
      `CPUDP_OP_OR:    y = a | b;
      `CPUDP_OP_XOR:   y = a ^ b;
      `CPUDP_OP_PASSB: y = b;
      `CPUDP_OP_SHL: begin
        y    = {a[14:0], cin};
        cout = a[15];
      end
      default: begin
        y    = {cin, a[15:1]};
        cout = a[0];
      end
    endcase
  end
endmodule

// ---- hdl/cpudp_paging.v ----
// paging unit: four 64-entry page tables and virtual to physical mapping
module cpudp_paging #(
  parameter TABLES = 4,
  parameter ENTRIES = 64
) (
  input  wire        clk,
  input  wire        map_we,
  input  wire [7:0]  map_addr,
  input  wire [15:0] map_wdata,
  output wire [15:0] map_rdata,
  input  wire [15:0] vaddr,
  input  wire        paging_on,
  input  wire        alt_page_table_sel,
  output reg  [17:0] paddr
);
  reg [15:0] page_map [0:TABLES*ENTRIES-1];
  wire [7:0] xidx;

  // table 0 normally, table 1 when the alternate table is selected
  assign xidx      = {1'b0, alt_page_table_sel, vaddr[15:10]};
  assign map_rdata = page_map[map_addr];

  // page map written over the data path by microcode
  always @(posedge clk) begin
    if (map_we) begin
      page_map[map_addr] <= map_wdata;
    end
  end

  // low 8 bits of an entry give the physical page, 1024 words a page
  always @* begin
    if (paging_on) begin
      paddr = {page_map[xidx][7:0], vaddr[9:0]};
    end else begin
      paddr = {2'b00, vaddr};
    end
  end
endmodule

// ---- hdl/cpudp_core.v ----
// microprogrammed processor slice: fetch, sequencing, arithmetic, status
// Overview of operation
// - data words travel on a 16-bit bus, one word at a time
// - memory addresses leave on an 18-bit physical address bus
// - paging maps 16-bit virtual to 18-bit physical; map is read/writable
// - microprogram store holds 1024 words of 32 bits
// - fetch drives instruction pointer, requests memory, latches instruction
// - entry point from instruction loads sequence counter; microword latched
// - one micro cycle lasts 6 clocks (260 ns rounded up to 300 ns), timed by a counter with the microword
// - next microword fetched during execution; sequence counter increments
// - sequence-end flag stops microsequence and starts next instruction fetch
// - memory operands and fetched instructions enter through operand register
// - displacement comes from low byte of the operand register
// - two 16-bit slices; one for integer, both joined for float
// - status flags come from the most significant slice only
// - both operands chosen together; second excludes status word
// - result written to A, A+D, A+D+T or another register
// - status low byte per level, high byte shared by all levels
// - bit 15 irq on, 14 paging on, 11-8 current level
// - bit 7 keeps shifted-out bit, bit 6 carry per operation
// - bit 5 sticky overflow until cleared, bit 4 dynamic overflow
// - bit 3 sticky error flag, optionally raises an interrupt request
// - bit 2 one-bit accumulator, bit 1 rounding, bit 0 alternate table
// - low status byte written and read by bit ops and byte moves
`include "cpudp_map.vh"
module cpudp_core #(
  parameter UWORDS = 1024,
  parameter UAW    = 10
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] info_bus_in,
  input  wire        mem_ack,
  input  wire [3:0]  cur_level,
  input  wire        irq_system_on,
  input  wire        paging_on,
  input  wire        err_event,
  input  wire        err_irq_en,
  input  wire        ucode_we,
  input  wire [9:0]  ucode_addr,
  input  wire [31:0] ucode_wdata,
  output wire [17:0] phys_addr_bus,
  output wire        mem_req,
  output wire [15:0] status_word,
  output wire        err_irq_req,
  output wire [15:0] instr_pointer
);
  localparam [5:0] S_IREQ  = 6'h01;
  localparam [5:0] S_IWAIT = 6'h02;
  localparam [5:0] S_ENTRY = 6'h04;
  localparam [5:0] S_UFET  = 6'h08;
  localparam [5:0] S_EXEC  = 6'h10;
  localparam [5:0] S_OREQ  = 6'h20;
  localparam integer UCYC = `CPUDP_UCYC;
  localparam [2:0] UCYC_LAST = UCYC[2:0] - 3'h1;

  // entry point generator: opcode field selects a 16-word block
  function [9:0] cpudp_entry;
    input [15:0] instr;
    begin
      cpudp_entry = {instr[15:10], 4'h0};
    end
  endfunction

  // flat index of a register on the current level
  function [6:0] cpudp_ridx;
    input [3:0] lvl;
    input [2:0] r;
    begin
      cpudp_ridx = {lvl, r};
    end
  endfunction

  reg [31:0] ustore [0:UWORDS-1];
  reg [15:0] regs [0:127];
  reg [5:0]  state_ff;
  reg [UAW-1:0] mpc_ff;
  reg [31:0] mir_ff;
  reg [31:0] mir_nxt_ff;
  reg [15:0] ir_ff;
  reg [15:0] h_ff;
  reg [2:0]  ucnt_ff;
  reg        op_done_ff;
  reg [17:0] phys_addr_bus_ff;
  reg        mem_req_ff;
  reg [15:0] status_word_ff;
  reg        err_irq_req_ff;
  reg [15:0] instr_pointer_ff;

  wire [2:0]  uop   = mir_ff[`CPUDP_UW_OP_HI:`CPUDP_UW_OP_LO];
  wire [2:0]  asel  = mir_ff[`CPUDP_UW_AS_HI:`CPUDP_UW_AS_LO];
  wire [2:0]  bsel  = mir_ff[`CPUDP_UW_BS_HI:`CPUDP_UW_BS_LO];
  wire [1:0]  bsrc  = mir_ff[`CPUDP_UW_BSRC_HI:`CPUDP_UW_BSRC_LO];
  wire [2:0]  wb    = mir_ff[`CPUDP_UW_WB_HI:`CPUDP_UW_WB_LO];
  wire [1:0]  stsop = mir_ff[`CPUDP_UW_SO_HI:`CPUDP_UW_SO_LO];
  wire [2:0]  bidx  = mir_ff[`CPUDP_UW_BI_HI:`CPUDP_UW_BI_LO];
  wire [2:0]  bfn   = mir_ff[`CPUDP_UW_BF_HI:`CPUDP_UW_BF_LO];
  wire        wide  = mir_ff[`CPUDP_UW_WIDE];

  wire [15:0] r_p   = regs[cpudp_ridx(cur_level, `CPUDP_R_P)];
  wire [15:0] r_a   = regs[cpudp_ridx(cur_level, `CPUDP_R_A)];
  wire [15:0] r_d   = regs[cpudp_ridx(cur_level, `CPUDP_R_D)];
  wire [15:0] r_x   = regs[cpudp_ridx(cur_level, `CPUDP_R_X)];
  wire [7:0]  sts_lo = regs[cpudp_ridx(cur_level, `CPUDP_R_STS)][7:0];
  // shared upper byte, bits 13-12 fixed at zero
  wire [15:0] sts_full = {irq_system_on, paging_on, 2'b00, cur_level,
                          sts_lo};

  wire        commit = (state_ff == S_EXEC) && (ucnt_ff == UCYC_LAST);
  wire        opf_go = (state_ff == S_EXEC) && (ucnt_ff == 3'h0) &&
                       !op_done_ff && mir_ff[`CPUDP_UW_OPF];
  // pc-relative address with signed displacement from h
  wire [15:0] eff_addr = r_p + {{8{h_ff[7]}}, h_ff[7:0]};
  wire [15:0] vaddr = (state_ff == S_IREQ) ? r_p : eff_addr;

  reg  [15:0] a_op;
  reg  [15:0] b_op;
  wire [15:0] lo_y;
  wire [15:0] hi_y;
  wire        lo_c;
  wire        hi_c;
  wire        hi_v;
  wire        is_sub = (uop == `CPUDP_OP_SUB);
  wire        is_sh  = (uop == `CPUDP_OP_SHL) || (uop == `CPUDP_OP_SHR);
  wire        cin_lo = is_sub ? 1'b1 : sts_lo[`CPUDP_S_M];
  wire        cin_hi = wide ? lo_c : cin_lo;
  wire [15:0] map_rdata;
  wire [17:0] paddr;
  wire        map_we = commit && mir_ff[`CPUDP_UW_PM] && mir_ff[`CPUDP_UW_PMW];
  reg  [7:0]  nxt_sts;

  // both operand selectors choose in the same cycle
  always @* begin
    if (asel == `CPUDP_R_STS) begin
      a_op = sts_full;
    end else begin
      a_op = regs[cpudp_ridx(cur_level, asel)];
    end
    case (bsrc)
      2'h0: b_op = (bsel == `CPUDP_R_STS) ? 16'h0000 :
                   regs[cpudp_ridx(cur_level, bsel)];
      2'h1: b_op = h_ff;
      2'h3: b_op = ir_ff;
      default: b_op = 16'h0000;
    endcase
  end

  // low slice works only in wide mode; integer work uses the high slice
  cpudp_alu16 u_alu_lo (
    .op   (uop),
    .a    (wide ? r_d : 16'h0000),
    .b    (wide ? h_ff : 16'h0000),
    .cin  (wide ? cin_lo : 1'b0),
    .y    (lo_y),
    .cout (lo_c),
    .ovf  ()
  );

  cpudp_alu16 u_alu_hi (
    .op   (uop),
    .a    (a_op),
    .b    (b_op),
    .cin  (cin_hi),
    .y    (hi_y),
    .cout (hi_c),
    .ovf  (hi_v)
  );

  // page map reached via x as index and a as data
  cpudp_paging u_paging (
    .clk                (clk),
    .map_we             (map_we),
    .map_addr           (r_x[7:0]),
    .map_wdata          (r_a),
    .map_rdata          (map_rdata),
    .vaddr              (vaddr),
    .paging_on          (paging_on),
    .alt_page_table_sel (sts_lo[`CPUDP_S_PM]),
    .paddr              (paddr)
  );

  // next low status byte; hardware sets land after software writes
  always @* begin
    nxt_sts = sts_lo;
    if (commit && stsop == 2'h3) begin
      nxt_sts = r_a[7:0];
    end
    if (commit && stsop == 2'h1) begin
      case (bfn)
        3'h0: nxt_sts[`CPUDP_S_K] = sts_lo[bidx];
        3'h1: nxt_sts[`CPUDP_S_K] = sts_lo[`CPUDP_S_K] & sts_lo[bidx];
        3'h2: nxt_sts[`CPUDP_S_K] = sts_lo[`CPUDP_S_K] | sts_lo[bidx];
        3'h3: nxt_sts[bidx] = sts_lo[`CPUDP_S_K];
        3'h4: nxt_sts[bidx] = 1'b1;
        3'h5: nxt_sts[bidx] = 1'b0;
        default: nxt_sts[`CPUDP_S_K] = ~sts_lo[`CPUDP_S_K];
      endcase
    end
    if (commit && mir_ff[`CPUDP_UW_FLG]) begin
      nxt_sts[`CPUDP_S_C] = hi_c;
      nxt_sts[`CPUDP_S_Q] = hi_v;
      if (hi_v) begin
        nxt_sts[`CPUDP_S_O] = 1'b1;
      end
      if (is_sh) begin
        nxt_sts[`CPUDP_S_M] = hi_c;
      end
    end
    if (err_event) begin
      nxt_sts[`CPUDP_S_Z] = 1'b1;
    end
  end

  // microprogram store load port
  always @(posedge clk) begin
    if (ucode_we) begin
      ustore[ucode_addr] <= ucode_wdata;
    end
  end

  // register block: status, pointer advance, result write-back
  always @(posedge clk) begin
    regs[cpudp_ridx(cur_level, `CPUDP_R_STS)] <= {8'h00, nxt_sts};
    if (state_ff == S_IWAIT && mem_ack) begin
      regs[cpudp_ridx(cur_level, `CPUDP_R_P)] <= r_p + 16'h0001;
    end
    if (commit) begin
      case (wb)
        3'h1: regs[cpudp_ridx(cur_level, `CPUDP_R_A)] <= hi_y;
        3'h2: begin
          regs[cpudp_ridx(cur_level, `CPUDP_R_A)] <= hi_y;
          regs[cpudp_ridx(cur_level, `CPUDP_R_D)] <= lo_y;
        end
        3'h3: begin
          regs[cpudp_ridx(cur_level, `CPUDP_R_A)] <= hi_y;
          regs[cpudp_ridx(cur_level, `CPUDP_R_D)] <= lo_y;
          regs[cpudp_ridx(cur_level, `CPUDP_R_T)] <= h_ff;
        end
        3'h4: begin
          if (asel != `CPUDP_R_STS) begin
            regs[cpudp_ridx(cur_level, asel)] <= hi_y;
          end
        end
        default: ;
      endcase
      if (stsop == 2'h2) begin
        regs[cpudp_ridx(cur_level, `CPUDP_R_A)] <= sts_full;
      end else if (mir_ff[`CPUDP_UW_PM] && !mir_ff[`CPUDP_UW_PMW]) begin
        regs[cpudp_ridx(cur_level, `CPUDP_R_A)] <= map_rdata;
      end
    end
  end

  // fetch and microsequencing control
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff         <= S_IREQ;
      mpc_ff           <= {UAW{1'b0}};
      mir_ff           <= 32'h00000000;
      mir_nxt_ff       <= 32'h00000000;
      ir_ff            <= 16'h0000;
      h_ff             <= 16'h0000;
      ucnt_ff          <= 3'h0;
      op_done_ff       <= 1'b0;
      phys_addr_bus_ff <= 18'h00000;
      mem_req_ff       <= 1'b0;
    end else begin
      case (state_ff)
        S_IREQ: begin
          phys_addr_bus_ff <= paddr;
          mem_req_ff       <= 1'b1;
          state_ff         <= S_IWAIT;
        end
        S_IWAIT: begin
          if (mem_ack) begin
            mem_req_ff <= 1'b0;
            ir_ff      <= info_bus_in;
            h_ff       <= info_bus_in;
            state_ff   <= S_ENTRY;
          end
        end
        S_ENTRY: begin
          mpc_ff   <= cpudp_entry(ir_ff);
          state_ff <= S_UFET;
        end
        S_UFET: begin
          mir_ff     <= ustore[mpc_ff];
          mpc_ff     <= mpc_ff + 1'b1;
          ucnt_ff    <= 3'h0;
          op_done_ff <= 1'b0;
          state_ff   <= S_EXEC;
        end
        S_EXEC: begin
          if (opf_go) begin
            phys_addr_bus_ff <= paddr;
            mem_req_ff       <= 1'b1;
            state_ff         <= S_OREQ;
          end else begin
            if (ucnt_ff == 3'h0) begin
              mir_nxt_ff <= ustore[mpc_ff];
              mpc_ff     <= mpc_ff + 1'b1;
            end
            if (ucnt_ff == UCYC_LAST) begin
              ucnt_ff    <= 3'h0;
              op_done_ff <= 1'b0;
              if (mir_ff[`CPUDP_UW_END]) begin
                state_ff <= S_IREQ;
              end else begin
                mir_ff <= mir_nxt_ff;
              end
            end else begin
              ucnt_ff <= ucnt_ff + 3'h1;
            end
          end
        end
        S_OREQ: begin
          if (mem_ack) begin
            mem_req_ff <= 1'b0;
            h_ff       <= info_bus_in;
            op_done_ff <= 1'b1;
            state_ff   <= S_EXEC;
          end
        end
        default: state_ff <= S_IREQ;
      endcase
    end
  end

  // registered views of status, pointer and error request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_word_ff   <= 16'h0000;
      err_irq_req_ff   <= 1'b0;
      instr_pointer_ff <= 16'h0000;
    end else begin
      status_word_ff   <= sts_full;
      err_irq_req_ff   <= nxt_sts[`CPUDP_S_Z] & err_irq_en;
      instr_pointer_ff <= r_p;
    end
  end

  assign phys_addr_bus = phys_addr_bus_ff;
  assign mem_req       = mem_req_ff;
  assign status_word   = status_word_ff;
  assign err_irq_req   = err_irq_req_ff;
  assign instr_pointer = instr_pointer_ff;
endmodule

// ---- testbench/cpudp_asserts.sv ----
// port checker for the processor slice
module cpudp_asserts (
  input wire        clk,
  input wire        rst,
  input wire        mem_ack,
  input wire [3:0]  cur_level,
  input wire        irq_system_on,
  input wire        paging_on,
  input wire        err_event,
  input wire        err_irq_en,
  input wire [17:0] phys_addr_bus,
  input wire        mem_req,
  input wire [15:0] status_word,
  input wire        err_irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic up_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // marks cycles after the first edge out of reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      up_ff <= 1'b0;
    end else begin
      up_ff <= 1'b1;
    end
  end
  // memory answer followed by the quiet gap before the next fetch
  sequence s_ack;
    mem_req && mem_ack;
  endsequence
  sequence s_quiet;
    !mem_req [*3];
  endsequence
  AST_ADDR_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && phys_addr_bus === $past(phys_addr_bus))
    else $error("request or address moved before the answer");
  AST_FETCH_GAP: assert property (s_ack |=> s_quiet)
    else $error("request not dropped after the answer");
  AST_HI_BYTE: assert property (up_ff |->
    status_word[15:8] == {$past(irq_system_on), $past(paging_on), 2'b00,
                          $past(cur_level)})
    else $error("shared status byte wrong");
  AST_UNUSED_ZERO: assert property (
    status_word[13:12] == 2'b00)
    else $error("unassigned status bits not zero");
  AST_ERR_SET: assert property (
    err_event |-> ##[1:2] status_word[3])
    else $error("error flag not set by error event");
  AST_ERR_MASK: assert property (!err_irq_en |=> !err_irq_req)
    else $error("error request while routing off");
  AST_ERR_IRQ_STS: assert property (
    err_irq_req |-> ##[0:1] status_word[3])
    else $error("error request without error flag");
  AST_PHYS_DIRECT: assert property (
    $rose(mem_req) && !paging_on && !$past(paging_on)
    |-> phys_addr_bus[17:16] == 2'b00)
    else $error("untranslated address has upper bits set");
endmodule

bind cpudp_core cpudp_asserts u_chk (.clk, .rst, .mem_ack, .cur_level,
  .irq_system_on, .paging_on, .err_event, .err_irq_en, .phys_addr_bus,
  .mem_req, .status_word, .err_irq_req);

// ---- testbench/cpudp_mem_model.sv ----
// memory partner: answers each request with one queued word
module cpudp_mem_model (
  input  wire         clk,
  input  wire         rst,
  input  wire         mem_req,
  input  wire  [17:0] phys_addr_bus,
  output logic [15:0] info_bus_in,
  output logic        mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] q [$];
  logic [17:0] last_addr;
  int          dly;
  // one word per request after a random wait; idle bus toggles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack     <= 1'b0;
      info_bus_in <= 16'h5a5a;
      dly         <= 0;
    end else begin
      info_bus_in <= ~info_bus_in;
      mem_ack     <= 1'b0;
      if (!mem_req || mem_ack) begin
        dly <= $urandom_range(3, 0);
      end else if (dly != 0) begin
        dly <= dly - 1;
      end else if (q.size() != 0) begin
        mem_ack     <= 1'b1;
        info_bus_in <= q.pop_front();
        last_addr   <= phys_addr_bus;
      end
    end
  end
endmodule

// ---- testbench/cpudp_core_test.sv ----
// self-checking bench for the processor slice and its memory
`include "cpudp_map.vh"
module cpudp_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst;
  logic [15:0] info_bus_in;
  logic        mem_ack;
  logic [3:0]  cur_level;
  logic        irq_system_on;
  logic        paging_on;
  logic        err_event;
  logic        err_irq_en;
  logic        ucode_we;
  logic [9:0]  ucode_addr;
  logic [31:0] ucode_wdata;
  wire  [17:0] phys_addr_bus;
  wire         mem_req;
  wire  [15:0] status_word;
  wire         err_irq_req;
  wire  [15:0] instr_pointer;
  int          err_count;
  int          check_count;
  logic [7:0]  lo [2];
  logic [15:0] pe [2];
  logic [1:0]  pk;
  logic [1:0]  mk;
  logic [5:0]  opc [5] = '{6'h01, 6'h21, 6'h02, 6'h03, 6'h04};

  cpudp_core dut (.clk(clk), .rst(rst), .info_bus_in(info_bus_in),
    .mem_ack(mem_ack), .cur_level(cur_level), .irq_system_on(irq_system_on),
    .paging_on(paging_on), .err_event(err_event), .err_irq_en(err_irq_en),
    .ucode_we(ucode_we), .ucode_addr(ucode_addr), .ucode_wdata(ucode_wdata),
    .phys_addr_bus(phys_addr_bus), .mem_req(mem_req),
    .status_word(status_word), .err_irq_req(err_irq_req),
    .instr_pointer(instr_pointer));
  cpudp_mem_model mm (.clk(clk), .rst(rst), .mem_req(mem_req),
    .phys_addr_bus(phys_addr_bus), .info_bus_in(info_bus_in),
    .mem_ack(mem_ack));

  // bench clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test;
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // microword builder; A selector fixed to the program counter
  function automatic logic [31:0] uw(input logic e, input logic [2:0] op,
    input logic [1:0] bs, input logic [2:0] wb, input logic [1:0] so,
    input logic [2:0] bi, input logic [2:0] bf, input logic f);
    uw = {e, op, `CPUDP_R_P, 3'h0, bs, 1'b0, wb, 1'b0, so, bi, bf, 2'h0,
          f, 4'h0};
  endfunction

  // doubling of a word plus the link bit: carry, signed overflow, sum
  function automatic logic [17:0] add_exp(input logic [15:0] w,
    input logic c);
    logic [16:0] s;
    s = {1'b0, w} + {1'b0, w} + {16'h0000, c};
    add_exp = {s[16], s[15] ^ w[15], s[15:0]};
  endfunction

  task automatic ld(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    ucode_we    <= 1'b1;
    ucode_addr  <= a;
    ucode_wdata <= d;
  endtask

  // hand one instruction (and its operand) over, wait for the next fetch
  task automatic run(input logic [15:0] w, input logic [15:0] d,
    input bit op);
    int n;
    n = 0;
    #1;
    mm.q.push_back(w);
    if (op) begin
      mm.q.push_back(d);
    end
    @(posedge clk);
    #1;
    while (mm.q.size() != 0 || mem_req !== 1'b1 || mem_ack !== 1'b0) begin
      n++;
      if (n > 300) begin
        err_count++;
        finish_test();
      end
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic chk_sts(input int l);
    logic [15:0] e;
    logic [15:0] m;
    e = {irq_system_on, paging_on, 2'b00, cur_level, lo[l]};
    m = mk[l] ? 16'hffff : 16'hff7f;
    chk(status_word & m, e & m);
  endtask

  // kinds: 0 clear low byte, 1/2 double with flags, 3 bit operations,
  // 4 operand fetch whose low byte is moved into the status word
  task automatic step(input int k);
    logic [15:0] w;
    logic [15:0] d;
    logic [17:0] s;
    int l;
    l = cur_level[0];
    w = {opc[k], 10'($urandom_range(1023, 0))};
    d = 16'($urandom_range(65535, 0));
    run(w, d, k == 4);
    s = add_exp(w, lo[l][7]);
    pe[l] += 16'h0001;
    if (k == 0) begin
      lo[l] = 8'h00;
      mk[l] = 1'b1;
    end else if (k == 3) begin
      lo[l][1] = 1'b1;
      lo[l][2] = ~lo[l][2];
    end else if (k == 4) begin
      lo[l] = d[7:0];
      mk[l] = 1'b1;
    end else begin
      pe[l] = s[15:0];
      pk[l] = 1'b1;
      mk[l] = 1'b0;
      lo[l][6] = s[17];
      lo[l][4] = s[16];
      lo[l][5] = lo[l][5] | s[16];
    end
    chk_sts(l);
    if (pk[l]) begin
      chk(instr_pointer, pe[l]);
    end
    if (pk[l] && !paging_on) begin
      chk(phys_addr_bus[15:0], pe[l]);
      chk({14'h0, phys_addr_bus[17:16]}, 16'h0000);
    end
    // operand address is the pointer plus the signed displacement
    if (k == 4 && pk[l] && !paging_on) begin
      chk(mm.last_addr[15:0], pe[l] + {{8{w[7]}}, w[7:0]});
    end
  endtask

  task automatic err(input logic en);
    int l;
    l = cur_level[0];
    @(posedge clk);
    err_irq_en <= en;
    err_event  <= 1'b1;
    @(posedge clk);
    err_event <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    lo[l][3] = 1'b1;
    chk_sts(l);
    chk({15'h0, err_irq_req}, {15'h0, en});
  endtask

  task automatic setl(input logic [3:0] lv);
    @(posedge clk);
    cur_level     <= lv;
    irq_system_on <= 1'($urandom_range(1, 0));
    paging_on     <= 1'($urandom_range(1, 0));
    repeat (3) @(posedge clk);
    #1;
    chk_sts(lv[0]);
  endtask

  // main sequence: microstore load, directed cases, random mix
  initial begin
    rst = 1'b1;
    cur_level = 4'hc;
    irq_system_on = 1'b0;
    paging_on = 1'b0;
    err_event = 1'b0;
    err_irq_en = 1'b0;
    ucode_we = 1'b0;
    ucode_addr = 10'h000;
    ucode_wdata = 32'h0000_0000;
    err_count = 0;
    check_count = 0;
    pk = 2'b00;
    mk = 2'b00;
    void'($urandom(32'h40c6));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      ld({6'h01, 4'(i)}, uw(i == 7, 3'h0, 2'h0, 3'h0, 2'h1, 3'(i), 3'h5, 1'b0));
    end
    for (int j = 1; j < 3; j++) begin
      ld({opc[j], 4'h0}, uw(1'b0, `CPUDP_OP_PASSB, 2'h1, 3'h4, 2'h0, 3'h0,
                            3'h0, 1'b0));
      ld({opc[j], 4'h1}, uw(1'b1, `CPUDP_OP_ADD, 2'h1, 3'h4, 2'h0, 3'h0,
                            3'h0, 1'b1));
    end
    ld({6'h03, 4'h0}, uw(1'b0, 3'h0, 2'h0, 3'h0, 2'h1, 3'h1, 3'h4, 1'b0));
    ld({6'h03, 4'h1}, uw(1'b1, 3'h0, 2'h0, 3'h0, 2'h1, 3'h0, 3'h6, 1'b0));
    // operand fetch into a, then a low byte into the status word
    ld({6'h04, 4'h0}, uw(1'b0, `CPUDP_OP_PASSB, 2'h1, 3'h1, 2'h0, 3'h0,
                         3'h0, 1'b0) | 32'h0000_8000);
    ld({6'h04, 4'h1}, uw(1'b1, 3'h0, 2'h0, 3'h0, 2'h3, 3'h0,
                         3'h0, 1'b0));
    @(posedge clk);
    ucode_we <= 1'b0;
    step(0);
    @(posedge clk);
    cur_level <= 4'h3;
    step(0);
    step(1);
    step(2);
    step(3);
    step(4);
    err(1'b1);
    err(1'b0);
    setl(4'hc);
    step(0);
    for (int i = 0; i < 16; i++) begin
      setl($urandom_range(1, 0) ? 4'h3 : 4'hc);
      step($urandom_range(4, 0));
      if ($urandom_range(1, 0)) begin
        err(1'($urandom_range(1, 0)));
      end
    end
    finish_test();
  end
endmodule
